//--- icm_counter.sv
// One channel of a programmable interval counter, modes 0 to 3
// Notes on behaviour
// [R1] Zero count means 10000H steps
// [R2] Host avoids count 1 in modes 2, 3
// [R3] Mode 0: control word drives output low
// [R4] Mode 0: gate high counts, low suspends
// [R5] Mode 0: load next clock, high at N+1
// [R6] Mode 0: first byte halts, forces low
// [R7] Mode 0: count loads even with gate low
// [R8] Mode 1: trigger loads, output low N clocks
// [R9] Mode 1: output stays high until retrigger
// [R10] Mode 1: gate fall ignored, rise reloads
// [R11] Mode 1: new count waits for retrigger
// [R12] Mode 2: low one clock at 1, period N
// [R13] Mode 2: gate low stops, forces high
// [R14] Mode 2: first low pulse N clocks later
// [R15] Mode 2: new count at trigger or cycle end
// [R16] Mode 3: square wave of period N
// [R17] Mode 3: gate low stops, forces high
// [R18] Control word fields select, format, mode, decimal
// [R19] Mode 3 even: step two, toggle at 2
// [R20] Mode 3 odd: high (N+1)/2 counts
// [R21] Element steps only on counter clock falls
// [R22] Decimal select counts four BCD digits
`timescale 1ns/1ps
`default_nettype none
module icm_counter #(
   parameter logic [1:0] CHAN_ID = icm_pkg::CHAN_RST // Channel number
) (
   input  wire logic        clk_i,                 // System clock
   input  wire logic        nrst_i,                // Sync reset, low
   input  wire logic        ctrl_wr_i,             // Control word strobe
   input  wire logic        count_wr_i,            // Count byte strobe
   input  wire logic [7:0]  data_i,                // Host write data
   input  wire logic        counter_clock_input_i, // Counter clock
   input  wire logic        counter_gate_input_i,  // Counter gate
   output logic             counter_output_pin_o,  // Counter output
   output logic [15:0]      count_value_o          // Counting element
);
   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   icm_pkg::icm_state_t st_r;      // Sequencing state
   logic [15:0] cr_r;              // count_holding_register
   logic [15:0] ce_r;              // Counting element
   logic [2:0]  mode_r;            // operating_mode_field, normalised
   logic [1:0]  rl_r;              // read_load_format_field
   logic        bcd_r;             // Decimal count select
   logic        msb_next_r;        // Next byte is the high byte
   logic        out_r;             // Output level
   logic        trig_r;            // Gate rise not yet consumed
   logic        clk_q_r;           // Counter clock, last sample
   logic        gate_q_r;          // Gate, last sample
   logic        tick_w;            // Counter clock falling edge
   logic        ctrl_we_w;         // Control word for this channel
   logic        last_byte_w;       // Count write completes the value
   logic        first_byte_w;      // First of a two-byte count
   logic        wr_any_w;          // Any write acting on this channel this cycle
   logic [2:0]  mode_nxt;          // Decoded mode of new control word
   logic [15:0] cr_nxt;            // Holding value after this byte

   // ---------------------------------------------------------------
   // Arithmetic helpers
   // ---------------------------------------------------------------
   // One step down, binary or four BCD digits; zero wraps to maximum
   function automatic logic [15:0] dec1(input logic [15:0] v,
                                        input logic        bcd);
      logic [15:0] r;
      logic        brw;
      r   = v;
      brw = 1'b1;
      if (!bcd) begin
         r = v - 16'h0001; // [R1]
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (brw) begin
               if (v[i*4 +: 4] == 4'h0) begin
                  r[i*4 +: 4] = 4'h9; // [R22]
               end else begin
                  r[i*4 +: 4] = v[i*4 +: 4] - 4'h1;
                  brw = 1'b0;
               end
            end
         end
      end
      return r;
   endfunction

   // ---------------------------------------------------------------
   // Edge detection and host decode
   // ---------------------------------------------------------------
   // Sample counter clock and gate for edge detection
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         clk_q_r  <= 1'b0;
         gate_q_r <= 1'b0;
      end else begin
         clk_q_r  <= counter_clock_input_i;
         gate_q_r <= counter_gate_input_i;
      end
   end

   assign tick_w = clk_q_r & ~counter_clock_input_i; // [R21]
   // Control words for other channels and latch commands pass by
   assign ctrl_we_w = ctrl_wr_i
                    & (data_i[icm_pkg::SEL_HI:icm_pkg::SEL_LO] == CHAN_ID)
                    & (data_i[icm_pkg::RL_HI:icm_pkg::RL_LO]
                       != icm_pkg::RL_LATCH); // [R18]
   // Modes with middle bit set ignore the top bit
   assign mode_nxt = data_i[2] ? {1'b0, data_i[2:1]}
                               : data_i[icm_pkg::MODE_HI:icm_pkg::MODE_LO];
   assign first_byte_w = count_wr_i & (rl_r == icm_pkg::RL_BOTH)
                       & ~msb_next_r;
   assign last_byte_w  = count_wr_i & ~first_byte_w;
   assign wr_any_w     = ctrl_we_w | count_wr_i;

   // Assemble the holding value from the written byte
   always_comb begin
      cr_nxt = cr_r;
      case (rl_r)
         icm_pkg::RL_LSB:  cr_nxt = {8'h00, data_i};
         icm_pkg::RL_MSB:  cr_nxt = {data_i, 8'h00};
         icm_pkg::RL_BOTH: cr_nxt = msb_next_r ? {data_i, cr_r[7:0]}
                                              : {cr_r[15:8], data_i};
         default:          cr_nxt = cr_r;
      endcase
   end

   // ---------------------------------------------------------------
   // Control word and holding register
   // ---------------------------------------------------------------
   // Store control fields, take count bytes
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         mode_r     <= icm_pkg::MODE_EVENT;
         rl_r       <= icm_pkg::RL_LSB;
         bcd_r      <= 1'b0;
         msb_next_r <= 1'b0;
         cr_r       <= icm_pkg::CE_RST;
      end else if (ctrl_we_w) begin
         mode_r     <= mode_nxt; // [R18]
         rl_r       <= data_i[icm_pkg::RL_HI:icm_pkg::RL_LO];
         bcd_r      <= data_i[icm_pkg::BCD_BIT];
         msb_next_r <= 1'b0;
      end else if (count_wr_i) begin
         cr_r       <= cr_nxt;
         msb_next_r <= first_byte_w;
      end
   end

   // Latch gate rising edge until the next counter clock fall
   // A rise in the same cycle as a tick wins and waits for the next tick
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         trig_r <= 1'b0;
      end else if (counter_gate_input_i && !gate_q_r) begin
         trig_r <= 1'b1; // [R10]
      end else if (ctrl_we_w || tick_w) begin
         trig_r <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Counting element, state and output
   // ---------------------------------------------------------------
   // Writes take priority; a counter clock fall in a write cycle is lost
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         st_r  <= icm_pkg::ICM_IDLE;
         ce_r  <= icm_pkg::CE_RST;
         out_r <= 1'b0;
      end else if (ctrl_we_w) begin
         // New control word: element cleared, output preset
         st_r  <= icm_pkg::ICM_IDLE;
         ce_r  <= icm_pkg::CE_RST;
         out_r <= (mode_nxt != icm_pkg::MODE_EVENT); // [R3] [R8] [R12] [R16]
      end else if (count_wr_i) begin
         if (mode_r == icm_pkg::MODE_EVENT) begin
            out_r <= 1'b0; // [R6]
            st_r  <= first_byte_w ? icm_pkg::ICM_IDLE
                                  : icm_pkg::ICM_WAIT; // [R6] [R7]
         end else if (last_byte_w && st_r == icm_pkg::ICM_IDLE) begin
            st_r  <= icm_pkg::ICM_WAIT; // [R11] [R15]
         end
      end else begin
         case (mode_r)
            icm_pkg::MODE_EVENT: begin
               if (tick_w && st_r == icm_pkg::ICM_WAIT) begin
                  ce_r <= cr_r; // [R5] [R7]
                  st_r <= icm_pkg::ICM_RUN;
               end else if (tick_w && st_r == icm_pkg::ICM_RUN
                            && counter_gate_input_i) begin
                  ce_r <= dec1(ce_r, bcd_r); // [R4]
                  if (ce_r == icm_pkg::CE_ONE) begin
                     out_r <= 1'b1; // [R3] [R5]
                  end
               end
            end
            icm_pkg::MODE_ONESHOT: begin
               if (tick_w && trig_r && st_r != icm_pkg::ICM_IDLE) begin
                  ce_r  <= cr_r; // [R8] [R10] [R11]
                  out_r <= 1'b0;
                  st_r  <= icm_pkg::ICM_RUN;
               end else if (tick_w && st_r == icm_pkg::ICM_RUN) begin
                  ce_r <= dec1(ce_r, bcd_r);
                  if (ce_r == icm_pkg::CE_ONE) begin
                     out_r <= 1'b1; // [R9]
                     st_r  <= icm_pkg::ICM_WAIT;
                  end
               end
            end
            icm_pkg::MODE_RATE: begin
               if (!counter_gate_input_i) begin
                  out_r <= 1'b1; // [R13]
               end else if (tick_w && st_r != icm_pkg::ICM_IDLE
                            && (trig_r || st_r == icm_pkg::ICM_WAIT)) begin
                  ce_r  <= cr_r; // [R13] [R14] [R15]
                  out_r <= 1'b1;
                  st_r  <= icm_pkg::ICM_RUN;
               end else if (tick_w && st_r == icm_pkg::ICM_RUN) begin
                  if (ce_r == icm_pkg::CE_ONE) begin
                     ce_r  <= cr_r; // [R12] [R15]
                     out_r <= 1'b1;
                  end else begin
                     ce_r  <= dec1(ce_r, bcd_r);
                     out_r <= (ce_r != icm_pkg::CE_TWO); // [R12]
                  end
               end
            end
            icm_pkg::MODE_SQUARE: begin
               if (!counter_gate_input_i) begin
                  out_r <= 1'b1; // [R17]
               end else if (tick_w && st_r != icm_pkg::ICM_IDLE
                            && (trig_r || st_r == icm_pkg::ICM_WAIT)) begin
                  ce_r  <= cr_r; // [R17]
                  out_r <= 1'b1;
                  st_r  <= icm_pkg::ICM_RUN;
               end else if (tick_w && st_r == icm_pkg::ICM_RUN) begin
                  if (ce_r == icm_pkg::CE_TWO) begin
                     out_r <= ~out_r; // [R16] [R19]
                     // Odd count: low half starts one shorter
                     ce_r  <= (out_r && cr_r[0]) ? dec1(cr_r, bcd_r)
                                                : cr_r; // [R20]
                  end else if (ce_r[0]) begin
                     ce_r <= dec1(ce_r, bcd_r); // [R20]
                  end else begin
                     ce_r <= dec1(dec1(ce_r, bcd_r), bcd_r); // [R19]
                  end
               end
            end
            default: begin
               // Modes 4 and 5 are not provided: hold
               st_r <= icm_pkg::ICM_IDLE;
            end
         endcase
      end
   end

   assign counter_output_pin_o = out_r;
   assign count_value_o        = ce_r;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   ctrl_out_low_a: assert property ( // [R3]
      @(posedge clk_i) disable iff (!nrst_i)
      ctrl_we_w && mode_nxt == icm_pkg::MODE_EVENT |=> !out_r)
      else $error("Mode 0 control word did not drive output low");
   ctrl_out_high_a: assert property ( // [R8]
      @(posedge clk_i) disable iff (!nrst_i)
      ctrl_we_w && mode_nxt != icm_pkg::MODE_EVENT |=> out_r)
      else $error("Control word did not preset output high");
   m0_load_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R5]
      !wr_any_w && tick_w && st_r == icm_pkg::ICM_WAIT
      && mode_r == icm_pkg::MODE_EVENT |=> ce_r == $past(cr_r) && !out_r)
      else $error("Mode 0 load did not copy holding value");
   m0_gate_hold_a: assert property ( // [R4]
      @(posedge clk_i) disable iff (!nrst_i)
      !wr_any_w && mode_r == icm_pkg::MODE_EVENT && st_r == icm_pkg::ICM_RUN
      && !counter_gate_input_i |=> $stable(ce_r) && $stable(out_r))
      else $error("Mode 0 counted with gate low");
   m0_first_byte_a: assert property ( // [R6]
      @(posedge clk_i) disable iff (!nrst_i)
      !ctrl_we_w && first_byte_w && mode_r == icm_pkg::MODE_EVENT
      |=> !out_r && st_r == icm_pkg::ICM_IDLE)
      else $error("Mode 0 first byte did not halt counting");
   m0_terminal_a: assert property ( // [R3]
      @(posedge clk_i) disable iff (!nrst_i)
      !wr_any_w && tick_w && mode_r == icm_pkg::MODE_EVENT
      && st_r == icm_pkg::ICM_RUN && counter_gate_input_i
      && ce_r == icm_pkg::CE_ONE |=> out_r && ce_r == icm_pkg::CE_RST)
      else $error("Mode 0 output not high at terminal count");
   m1_trigger_a: assert property ( // [R8]
      @(posedge clk_i) disable iff (!nrst_i)
      !wr_any_w && tick_w && trig_r && mode_r == icm_pkg::MODE_ONESHOT
      && st_r != icm_pkg::ICM_IDLE |=> !out_r && ce_r == $past(cr_r))
      else $error("Mode 1 trigger did not start pulse");
   m2_gate_low_a: assert property ( // [R13]
      @(posedge clk_i) disable iff (!nrst_i)
      !wr_any_w && mode_r == icm_pkg::MODE_RATE && !counter_gate_input_i
      |=> out_r && $stable(ce_r))
      else $error("Mode 2 gate low did not force output high");
   m2_pulse_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R12]
      !wr_any_w && tick_w && mode_r == icm_pkg::MODE_RATE
      && st_r == icm_pkg::ICM_RUN && counter_gate_input_i && !trig_r
      && ce_r == icm_pkg::CE_TWO |=> !out_r && ce_r == icm_pkg::CE_ONE)
      else $error("Mode 2 low pulse missing at count one");
   m3_gate_low_a: assert property ( // [R17]
      @(posedge clk_i) disable iff (!nrst_i)
      !wr_any_w && mode_r == icm_pkg::MODE_SQUARE && !counter_gate_input_i
      |=> out_r)
      else $error("Mode 3 gate low did not force output high");
   m3_toggle_a: assert property ( // [R19]
      @(posedge clk_i) disable iff (!nrst_i)
      !wr_any_w && tick_w && mode_r == icm_pkg::MODE_SQUARE
      && st_r == icm_pkg::ICM_RUN && counter_gate_input_i && !trig_r
      && ce_r == icm_pkg::CE_TWO |=> out_r != $past(out_r))
      else $error("Mode 3 output did not toggle at two");
endmodule // icm_counter
`default_nettype wire

//--- icm_host_model.sv
// Host-side model that turns write requests into bus strobes
`timescale 1ns/1ps
`default_nettype none
module icm_host_model (
   input  wire logic       clk_i,       // System clock
   input  wire logic       req_ctrl_i,  // Control word cycle wanted
   input  wire logic       req_count_i, // Count byte cycle wanted
   input  wire logic [7:0] req_data_i,  // Byte to write
   output logic            ctrl_wr_o,   // Control word strobe
   output logic            count_wr_o,  // Count byte strobe
   output logic [7:0]      data_o       // Write data
);
   // ---------------------------------------------------------------
   // Bus cycles
   // ---------------------------------------------------------------
   // One strobe per request cycle, launched on the rising edge
   always_ff @(posedge clk_i) begin
      ctrl_wr_o  <= req_ctrl_i;
      count_wr_o <= req_count_i & ~req_ctrl_i; // Control cycle wins
   end
   // Byte stands with its strobe; a released bus shows the inverse
   always_ff @(posedge clk_i) begin
      if (req_ctrl_i || req_count_i) begin
         data_o <= req_data_i;
      end else begin
         data_o <= ~req_data_i;
      end
   end
endmodule // icm_host_model
`default_nettype wire

//--- icm_pkg.sv
// Package with constants and types for the interval counter
package icm_pkg;
   // ---------------------------------------------------------------
   // Control word field positions
   // ---------------------------------------------------------------
   localparam int SEL_HI  = 7; // Counter select field, top bit
   localparam int SEL_LO  = 6; // Counter select field, low bit
   localparam int RL_HI   = 5; // Read/load format field, top bit
   localparam int RL_LO   = 4; // Read/load format field, low bit
   localparam int MODE_HI = 3; // Operating mode field, top bit
   localparam int MODE_LO = 1; // Operating mode field, low bit
   localparam int BCD_BIT = 0; // Decimal count select
   // ---------------------------------------------------------------
   // Read/load format codes
   // ---------------------------------------------------------------
   localparam logic [1:0] RL_LATCH = 2'h0; // Latch command, not handled
   localparam logic [1:0] RL_LSB   = 2'h1; // Low byte only
   localparam logic [1:0] RL_MSB   = 2'h2; // High byte only
   localparam logic [1:0] RL_BOTH  = 2'h3; // Low byte then high byte
   // ---------------------------------------------------------------
   // Operating modes (normalised, top bit dropped for modes 2 and 3)
   // ---------------------------------------------------------------
   localparam logic [2:0] MODE_EVENT  = 3'h0; // Terminal count event
   localparam logic [2:0] MODE_ONESHOT = 3'h1; // Gate-triggered one-shot
   localparam logic [2:0] MODE_RATE   = 3'h2; // Rate generator
   localparam logic [2:0] MODE_SQUARE = 3'h3; // Square-wave generator
   // ---------------------------------------------------------------
   // Reset values and counting constants
   // ---------------------------------------------------------------
   localparam logic [15:0] CE_RST   = 16'h0000; // Element after reset
   localparam logic [15:0] CE_ONE   = 16'h0001; // Terminal value
   localparam logic [15:0] CE_TWO   = 16'h0002; // Half-cycle end
   localparam logic [1:0]  CHAN_RST = 2'h0;     // Default channel number
   // Counter sequencing states, Gray along idle, wait, run
   typedef enum logic [1:0] {
      ICM_IDLE = 2'b00, // No count to act on
      ICM_WAIT = 2'b01, // Count written, awaiting load
      ICM_RUN  = 2'b11  // Counting element live
   } icm_state_t;
endpackage

//--- tb_interval_counter_modes.sv
// Testbench for one interval counter channel, modes 0 to 3
`timescale 1ns/1ps
`default_nettype none
module tb_interval_counter_modes;
   logic        clk_i      = 1'b0;  // System clock
   logic        nrst_i     = 1'b0;  // Sync reset, low
   logic        cclk       = 1'b1;  // Counter clock, starts high, idles low between ticks
   logic        gate       = 1'b0;  // Counter gate
   logic        req_ctrl   = 1'b0;  // Ask host for a control cycle
   logic        req_count  = 1'b0;  // Ask host for a count cycle
   logic [7:0]  req_data   = 8'h00; // Byte for the host to write
   logic        ctrl_wr;            // Control strobe
   logic        count_wr;           // Count strobe
   logic [7:0]  data;               // Write data
   logic        out;                // Counter output
   logic [15:0] cnt;                // Counting element
   int          n_fail     = 0;     // Mismatches
   int          num_checks = 0;     // Comparisons
   int          hi;                 // High ticks seen
   // ---------------------------------------------------------------
   // Clock, host model and design
   // ---------------------------------------------------------------
   always #5 clk_i = ~clk_i;
   icm_host_model host (
      .clk_i       (clk_i),
      .req_ctrl_i  (req_ctrl),
      .req_count_i (req_count),
      .req_data_i  (req_data),
      .ctrl_wr_o   (ctrl_wr),
      .count_wr_o  (count_wr),
      .data_o      (data)
   );
   icm_counter #(.CHAN_ID(2'h0)) DUT (
      .clk_i(clk_i), .nrst_i(nrst_i), .ctrl_wr_i(ctrl_wr),
      .count_wr_i(count_wr), .data_i(data),
      .counter_clock_input_i(cclk), .counter_gate_input_i(gate),
      .counter_output_pin_o(out), .count_value_o(cnt));
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // Compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen,
                  exp);
      end
   endtask
   // Verdict and end of run
   task automatic complete_run();
      if (n_fail == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Control word cycle; the host strobes one edge later
   task automatic wr_ctrl(input logic [1:0] sel, input logic [1:0] rl,
                          input logic [2:0] mode, input logic bcd);
      @(posedge clk_i);
      req_ctrl <= 1'b1;
      req_data <= {sel, rl, mode, bcd};
      @(posedge clk_i);
      req_ctrl <= 1'b0;
   endtask
   // Count byte cycle; never a count of 1 in modes 2 and 3
   task automatic wr_count(input logic [7:0] b);
      @(posedge clk_i);
      req_count <= 1'b1;
      req_data  <= b;
      @(posedge clk_i);
      req_count <= 1'b0;
   endtask
   // Let write effects land
   task automatic settle();
      repeat (2) @(posedge clk_i);
      #1;
   endtask
   // One counter clock fall, then wait until its effect shows
   task automatic tick();
      @(posedge clk_i);
      cclk <= 1'b1;
      repeat (2) @(posedge clk_i);
      cclk <= 1'b0;
      repeat (3) @(posedge clk_i);
      #1;
   endtask
   // Gate level change off the sampling instant
   task automatic set_gate(input logic v);
      @(posedge clk_i);
      gate <= v;
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   // Event counting: gate low load, suspend, two-byte rewrite
   task automatic sc_mode0();
      wr_ctrl(2'h0, 2'h3, 3'h0, 1'b0);
      settle();
      check(16'(out), 16'h0000);
      wr_count(8'h03);
      wr_count(8'h00);
      tick();
      check(cnt, 16'h0003);
      tick();
      check(cnt, 16'h0003);
      check(16'(out), 16'h0000);
      set_gate(1'b1);
      tick();
      tick();
      check(16'(out), 16'h0000);
      tick();
      check(16'(out), 16'h0001);
      wr_count(8'h02);
      settle();
      check(16'(out), 16'h0000);
      tick();
      check(cnt, 16'h0000);
      wr_count(8'h00);
      tick();
      check(cnt, 16'h0002);
      tick();
      check(16'(out), 16'h0000);
      tick();
      check(16'(out), 16'h0001);
   endtask
   // One-shot: trigger, gate fall, rewrite during pulse, retrigger
   task automatic sc_mode1();
      set_gate(1'b0);
      wr_ctrl(2'h0, 2'h1, 3'h1, 1'b0);
      settle();
      check(16'(out), 16'h0001);
      wr_count(8'h02);
      tick();
      check(16'(out), 16'h0001);
      set_gate(1'b1);
      tick();
      check(cnt, 16'h0002);
      check(16'(out), 16'h0000);
      set_gate(1'b0);
      wr_count(8'h03);
      tick();
      check(cnt, 16'h0001);
      check(16'(out), 16'h0000);
      tick();
      check(16'(out), 16'h0001);
      tick();
      check(16'(out), 16'h0001);
      set_gate(1'b1);
      tick();
      check(cnt, 16'h0003);
      check(16'(out), 16'h0000);
   endtask
   // Rate generator: foreign select, latch, pulse, gate stop, rewrite
   task automatic sc_mode2();
      wr_ctrl(2'h0, 2'h1, 3'h2, 1'b0);
      settle();
      check(16'(out), 16'h0001);
      wr_ctrl(2'h2, 2'h1, 3'h0, 1'b0);
      settle();
      check(16'(out), 16'h0001);
      wr_ctrl(2'h0, 2'h0, 3'h0, 1'b0);
      settle();
      check(16'(out), 16'h0001);
      wr_count(8'h03);
      tick();
      check(cnt, 16'h0003);
      tick();
      check(16'(out), 16'h0001);
      tick();
      check(16'(out), 16'h0000);
      tick();
      check(16'(out), 16'h0001);
      check(cnt, 16'h0003);
      tick();
      tick();
      check(16'(out), 16'h0000);
      set_gate(1'b0);
      settle();
      check(16'(out), 16'h0001);
      tick();
      check(cnt, 16'h0001);
      set_gate(1'b1);
      tick();
      check(cnt, 16'h0003);
      wr_count(8'h04);
      tick();
      check(cnt, 16'h0002);
      tick();
      tick();
      check(cnt, 16'h0004);
   endtask
   // Square wave: duty for even and odd counts, gate forcing high
   task automatic sc_mode3(input logic [7:0] n, input int exp_hi);
      wr_ctrl(2'h0, 2'h1, 3'h3, 1'b0);
      settle();
      check(16'(out), 16'h0001);
      wr_count(n);
      tick();
      hi = 0;
      for (int i = 0; i < 2 * int'(n); i++) begin
         tick();
         if (out === 1'b1) begin
            hi++;
         end
      end
      check(16'(hi), 16'(exp_hi));
      for (int i = 0; i < 8 && out !== 1'b0; i++) begin
         tick();
      end
      check(16'(out), 16'h0000);
      set_gate(1'b0);
      settle();
      check(16'(out), 16'h0001);
      set_gate(1'b1);
   endtask
   // Zero count wraps to the largest value; high-byte-only format
   task automatic sc_zero();
      for (int b = 0; b < 2; b++) begin
         wr_ctrl(2'h0, 2'h3, 3'h0, b[0]);
         wr_count(8'h00);
         wr_count(8'h00);
         tick();
         check(cnt, 16'h0000);
         tick();
         check(cnt, b[0] ? 16'h9999 : 16'hffff);
      end
      wr_ctrl(2'h0, 2'h2, 3'h0, 1'b0);
      wr_count(8'h01);
      tick();
      check(cnt, 16'h0100);
   endtask
   // ---------------------------------------------------------------
   // Main sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      repeat (8) @(posedge clk_i);
      nrst_i <= 1'b1;
      sc_mode0();
      sc_mode1();
      set_gate(1'b1);
      sc_mode2();
      sc_mode3(8'h04, 4);
      sc_mode3(8'h05, 6);
      sc_zero();
      complete_run();
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      n_fail++;
      complete_run();
   end
endmodule // tb_interval_counter_modes
`default_nettype wire
